// *** logic/cfs_defs.vh ***
// Constants for the closed loop feedback select block.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz control clock.
// Contract
// [R1] Mode 0 semi loop, mode 1 load units
// [R2] Selection 1: command off semi, on full
// [R3] Selection only counts in fully closed system
// [R4] Absolute detection: semi, or selection 0 absolute
// [R5] Scale motor pulses by num product/den product
// [R6] Host keeps load pulses/rev within 4096..67108864
// [R7] Bad gear raises parameter alarm, deviation alarm
// [R8] Load cumulative counter follows load encoder
// [R9] Reference mark clears load information to zero
// [R10] Polarity bit reverses load counting direction
// [R11] Scaled and raw motor counts stay readable
// [R12] Host selects full mode before load checks
// [R13] Filter 0 semi, 18000 full, between blends
// [R14] Gear remainder carried, no drift accumulates
`ifndef CFS_DEFS_VH
`define CFS_DEFS_VH

`define CFS_A_CTRL        8'h00
`define CFS_A_NUM1        8'h04
`define CFS_A_NUM2        8'h08
`define CFS_A_DEN1        8'h0c
`define CFS_A_DEN2        8'h10
`define CFS_A_FILTER      8'h14
`define CFS_A_DEV_LIMIT   8'h18
`define CFS_A_MOTOR_PPR   8'h1c
`define CFS_A_STATUS      8'h20
`define CFS_A_MOTOR_RAW   8'h24
`define CFS_A_MOTOR_SCL   8'h28
`define CFS_A_LOAD_CUM    8'h2c
`define CFS_A_LOAD_INFO   8'h30
`define CFS_A_FEEDBACK    8'h34
`define CFS_A_IRQ_STAT    8'h38
`define CFS_A_IRQ_EN      8'h3c
`define CFS_A_IRQ_CLR     8'h40

`define CFS_CTRL_MODE     0
`define CFS_CTRL_SEL      1
`define CFS_CTRL_POL      2

`define CFS_ST_CTL_LO     0
`define CFS_ST_CTL_HI     1
`define CFS_ST_ABS        2
`define CFS_ST_PAR_ALM    3
`define CFS_ST_DEV_ALM    4

`define CFS_IRQ_PAR       0
`define CFS_IRQ_DEV       1
`define CFS_IRQ_REF       2

`define CFS_CTL_SEMI      2'h0
`define CFS_CTL_DUAL      2'h1
`define CFS_CTL_FULL      2'h2

`define CFS_RST_CTRL      3'h0
`define CFS_RST_GEAR      16'h0001
`define CFS_RST_FILTER    15'h000a
`define CFS_RST_DEV_LIM   32'h00100000
`define CFS_RST_PPR       32'h00400000
`define CFS_FILTER_MAX    15'h4650
`define CFS_LOAD_MIN      58'h0000000_00001000
`define CFS_LOAD_MAX      58'h0000000_04000000

`define CFS_RESP_OKAY     2'h0
`define CFS_RESP_SLVERR   2'h2

`endif

// *** logic/cfs_gear.v ***
// Two-stage electronic gear: scales motor encoder steps to load units.
// Assumes numerator and denominator products are already formed and
// that the denominator is nonzero whenever samples arrive.
`default_nettype none
module cfs_gear (
  input  wire               ref_clk,   // Control clock
  input  wire               rst_n,     // Synchronised reset
  input  wire               smp_vld,   // Motor step sample valid
  input  wire signed [15:0] smp_delta, // Motor step in motor units
  input  wire        [31:0] num,       // Numerator product
  input  wire        [31:0] den,       // Denominator product
  output reg                step_vld_r,// Scaled step valid
  output reg  signed [31:0] step_r     // Scaled step in load units
);
  reg  signed [49:0] rem_r;
  wire signed [49:0] den_s;
  wire signed [49:0] acc;
  wire signed [49:0] quo;
  wire signed [49:0] rem_nxt;

  assign den_s   = (den == 32'h0) ? 50'sd1 : $signed({18'h0, den});
  // Leftover from the last division is added back in before dividing
  assign acc     = rem_r + smp_delta * $signed({18'h0, num}); // R14 R5
  assign quo     = acc / den_s;                               // R5
  assign rem_nxt = acc - quo * den_s;                         // R14

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r      <= 50'sd0;
      step_r     <= 32'sd0;
      step_vld_r <= 1'b0;
    end else begin
      step_vld_r <= smp_vld;
      if (smp_vld) begin
        rem_r  <= rem_nxt;
        step_r <= quo[31:0];
      end
    end
  end
endmodule // cfs_gear
`default_nettype wire

// *** logic/cfs_top.v ***
// Feedback source selection, gear scaling, counters and alarms.
// Assumes encoder steps arrive as signed deltas with a valid strobe,
// synchronous to ref_clk, and an AXI4-Lite master with one access
// of each kind outstanding.
//
// Implementation choices: the address map and register access over AXI4-Lite.
`default_nettype none
`include "cfs_defs.vh"
module cfs_top (
  input  wire               ref_clk,       // 20 MHz control clock
  input  wire               nrst,          // Async reset, active low
  input  wire               mot_vld,       // Motor encoder step valid
  input  wire signed [15:0] mot_delta,     // Motor encoder step
  input  wire               load_vld,      // Load encoder step valid
  input  wire signed [15:0] load_delta,    // Load encoder step
  input  wire               load_ref_mark, // Reference mark / Z pulse
  input  wire               load_is_abs,   // Load encoder is absolute
  input  wire               full_loop_cmd, // Controller loop select
  output reg         [1:0]  ctl_mode_r,    // 0 semi, 1 dual, 2 full
  output reg                load_units_r,  // Positions in load units
  output reg                abs_avail_r,   // Absolute detection ok
  output reg  signed [31:0] fb_pos_r,      // Blended feedback position
  output reg                par_alarm_r,   // Parameter error alarm
  output reg                dev_alarm_r,   // Position deviation alarm
  output reg                irq_r,         // Level interrupt
  input  wire        [7:0]  s_axi_awaddr,  // Write address
  input  wire               s_axi_awvalid, // Write address valid
  output reg                s_axi_awready, // Write address ready
  input  wire        [31:0] s_axi_wdata,   // Write data
  input  wire        [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire               s_axi_wvalid,  // Write data valid
  output reg                s_axi_wready,  // Write data ready
  output reg         [1:0]  s_axi_bresp,   // Write response
  output reg                s_axi_bvalid,  // Write response valid
  input  wire               s_axi_bready,  // Write response ready
  input  wire        [7:0]  s_axi_araddr,  // Read address
  input  wire               s_axi_arvalid, // Read address valid
  output reg                s_axi_arready, // Read address ready
  output reg         [31:0] s_axi_rdata,   // Read data
  output reg         [1:0]  s_axi_rresp,   // Read response
  output reg                s_axi_rvalid,  // Read data valid
  input  wire               s_axi_rready   // Read data ready
);
  reg rst_s1_r;
  reg rst_n_r;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Byte-lane merge, used for every writable register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i]) merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `CFS_A_IRQ_CLR);
    end
  endfunction

  reg        [2:0]  ctrl_r;
  reg        [15:0] num1_r, num2_r, den1_r, den2_r;
  reg        [14:0] filter_r;
  reg        [31:0] dev_lim_r, ppr_r;
  reg        [2:0]  irq_stat_r, irq_en_r;
  reg signed [31:0] mot_raw_r, mot_scl_r, load_cum_r, load_info_r;
  reg               par_prev_r, dev_prev_r;

  wire        op_full = ctrl_r[`CFS_CTRL_MODE];
  wire        sel_cmd = ctrl_r[`CFS_CTRL_SEL];
  wire [31:0] num_p   = num1_r * num2_r; // R5
  wire [31:0] den_p   = den1_r * den2_r; // R5

  // Load pulses per motor rev = ppr*num/den, checked without a divider
  wire [63:0] lhs     = ppr_r * num_p;
  wire [63:0] lo_b    = `CFS_LOAD_MIN * den_p;
  wire [63:0] hi_b    = `CFS_LOAD_MAX * den_p;
  wire        gear_bad = (num_p == 32'h0) || (den_p == 32'h0) ||
                         (lhs < lo_b) || (lhs > hi_b); // R7

  wire               step_vld;
  wire signed [31:0] step;
  cfs_gear u_gear (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n_r),
    .smp_vld    (mot_vld && !gear_bad),
    .smp_delta  (mot_delta),
    .num        (num_p),
    .den        (den_p),
    .step_vld_r (step_vld),
    .step_r     (step)
  );

  // Control selection
  reg [1:0] ctl_nxt;
  always @* begin
    if (!op_full)
      ctl_nxt = `CFS_CTL_SEMI;                          // R1 R3
    else if (sel_cmd)
      ctl_nxt = full_loop_cmd ? `CFS_CTL_FULL
                              : `CFS_CTL_SEMI;          // R2
    else if (filter_r == 15'h0)
      ctl_nxt = `CFS_CTL_SEMI;                          // R13
    else if (filter_r >= `CFS_FILTER_MAX)
      ctl_nxt = `CFS_CTL_FULL;                          // R13
    else
      ctl_nxt = `CFS_CTL_DUAL;                          // R13
  end
  wire abs_nxt = !op_full || (!sel_cmd && load_is_abs); // R4

  // Blend weight: 0 gives motor side, 18000 gives load side
  reg [14:0] wgt;
  always @* begin
    case (ctl_nxt)
      `CFS_CTL_SEMI: wgt = 15'h0;
      `CFS_CTL_FULL: wgt = `CFS_FILTER_MAX;
      `CFS_CTL_DUAL: wgt = filter_r;
      default:       wgt = 15'h0;
    endcase
  end
  // Semi mode in a motor-unit system reports raw motor counts
  wire signed [31:0] mot_pos = op_full ? mot_scl_r : mot_raw_r; // R1
  wire signed [31:0] gap     = load_cum_r - mot_scl_r;
  wire signed [47:0] gap_w   = gap * $signed({1'b0, wgt});
  wire signed [47:0] gap_q   = gap_w / 48'sd18000;
  wire signed [31:0] fb_nxt  = mot_pos + gap_q[31:0];           // R13
  wire [31:0] gap_abs = gap[31] ? (32'h0 - gap) : gap;
  wire dev_nxt = op_full && (gap_abs > dev_lim_r);               // R7

  wire signed [15:0] load_step = ctrl_r[`CFS_CTRL_POL] ?
                                 -load_delta : load_delta;       // R10

  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mot_raw_r    <= 32'sd0;
      mot_scl_r    <= 32'sd0;
      load_cum_r   <= 32'sd0;
      load_info_r  <= 32'sd0;
      ctl_mode_r   <= `CFS_CTL_SEMI;
      load_units_r <= 1'b0;
      abs_avail_r  <= 1'b0;
      fb_pos_r     <= 32'sd0;
      par_alarm_r  <= 1'b0;
      dev_alarm_r  <= 1'b0;
      par_prev_r   <= 1'b0;
      dev_prev_r   <= 1'b0;
    end else begin
      if (mot_vld)
        mot_raw_r <= mot_raw_r + mot_delta;                      // R11
      if (step_vld)
        mot_scl_r <= mot_scl_r + step;                           // R11
      if (load_vld)
        load_cum_r <= load_cum_r + load_step;                    // R8
      // The mark defines zero, so a same-cycle step is dropped
      if (load_ref_mark)
        load_info_r <= 32'sd0;                                   // R9
      else if (load_vld)
        load_info_r <= load_info_r + load_step;
      ctl_mode_r   <= ctl_nxt;
      load_units_r <= op_full;                                   // R1
      abs_avail_r  <= abs_nxt;
      fb_pos_r     <= fb_nxt;
      par_alarm_r  <= gear_bad;                                  // R7
      dev_alarm_r  <= dev_nxt;
      par_prev_r   <= par_alarm_r;
      dev_prev_r   <= dev_alarm_r;
    end
  end

  // Register bus
  reg        aw_hold_r, w_hold_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;
  wire       wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  // Merged words are cut to each register's own width where stored
  wire [31:0] ctrl_m = merge({29'h0, ctrl_r}, w_data_r, w_strb_r);
  wire [31:0] num1_m = merge({16'h0, num1_r}, w_data_r, w_strb_r);
  wire [31:0] num2_m = merge({16'h0, num2_r}, w_data_r, w_strb_r);
  wire [31:0] den1_m = merge({16'h0, den1_r}, w_data_r, w_strb_r);
  wire [31:0] den2_m = merge({16'h0, den2_r}, w_data_r, w_strb_r);
  wire [31:0] filt_m = merge({17'h0, filter_r}, w_data_r, w_strb_r);
  wire [31:0] en_m   = merge({29'h0, irq_en_r}, w_data_r, w_strb_r);
  wire [31:0] clr_m  = merge(32'h0, w_data_r, w_strb_r);
  wire [2:0]  irq_clr = (wr_go && aw_addr_r == `CFS_A_IRQ_CLR) ?
                        clr_m[2:0] : 3'h0;
  wire [2:0] irq_evt = {load_ref_mark, dev_alarm_r && !dev_prev_r,
                        par_alarm_r && !par_prev_r};
  wire [2:0] stat_nxt = (irq_stat_r & ~irq_clr) | irq_evt;

  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h0;
      w_data_r      <= 32'h0;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CFS_RESP_OKAY;
      ctrl_r        <= `CFS_RST_CTRL;
      num1_r        <= `CFS_RST_GEAR;
      num2_r        <= `CFS_RST_GEAR;
      den1_r        <= `CFS_RST_GEAR;
      den2_r        <= `CFS_RST_GEAR;
      filter_r      <= `CFS_RST_FILTER;
      dev_lim_r     <= `CFS_RST_DEV_LIM;
      ppr_r         <= `CFS_RST_PPR;
      irq_en_r      <= 3'h0;
      irq_stat_r    <= 3'h0;
      irq_r         <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awvalid ? 1'b1 :
                       (!aw_hold_r && !(s_axi_awvalid && s_axi_awready));
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r     <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r     <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_r) ? `CFS_RESP_OKAY
                                          : `CFS_RESP_SLVERR;
        case (aw_addr_r)
          `CFS_A_CTRL:
            ctrl_r <= ctrl_m[2:0];
          `CFS_A_NUM1:
            num1_r <= num1_m[15:0];
          `CFS_A_NUM2:
            num2_r <= num2_m[15:0];
          `CFS_A_DEN1:
            den1_r <= den1_m[15:0];
          `CFS_A_DEN2:
            den2_r <= den2_m[15:0];
          `CFS_A_FILTER:
            filter_r <= filt_m[14:0];
          `CFS_A_DEV_LIMIT:
            dev_lim_r <= merge(dev_lim_r, w_data_r, w_strb_r);
          `CFS_A_MOTOR_PPR:
            ppr_r <= merge(ppr_r, w_data_r, w_strb_r);
          `CFS_A_IRQ_EN:
            irq_en_r <= en_m[2:0];
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // New events win over a clear in the same cycle
      irq_stat_r <= stat_nxt;
      irq_r      <= |(stat_nxt & irq_en_r);
    end
  end

  reg [31:0] rd_val;
  always @* begin
    case (s_axi_araddr)
      `CFS_A_CTRL:      rd_val = {29'h0, ctrl_r};
      `CFS_A_NUM1:      rd_val = {16'h0, num1_r};
      `CFS_A_NUM2:      rd_val = {16'h0, num2_r};
      `CFS_A_DEN1:      rd_val = {16'h0, den1_r};
      `CFS_A_DEN2:      rd_val = {16'h0, den2_r};
      `CFS_A_FILTER:    rd_val = {17'h0, filter_r};
      `CFS_A_DEV_LIMIT: rd_val = dev_lim_r;
      `CFS_A_MOTOR_PPR: rd_val = ppr_r;
      `CFS_A_STATUS:    rd_val = {27'h0, dev_alarm_r, par_alarm_r,
                                  abs_avail_r, ctl_mode_r};
      `CFS_A_MOTOR_RAW: rd_val = mot_raw_r;
      `CFS_A_MOTOR_SCL: rd_val = mot_scl_r;
      `CFS_A_LOAD_CUM:  rd_val = load_cum_r;
      `CFS_A_LOAD_INFO: rd_val = load_info_r;
      `CFS_A_FEEDBACK:  rd_val = fb_pos_r;
      `CFS_A_IRQ_STAT:  rd_val = {29'h0, irq_stat_r};
      `CFS_A_IRQ_EN:    rd_val = {29'h0, irq_en_r};
      default:          rd_val = 32'h0;
    endcase
  end

  always @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `CFS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `CFS_RESP_OKAY
                                              : `CFS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // cfs_top
`default_nettype wire

// *** verification/cfs_enc_model.sv ***
// Load-side encoder model: a burst of equal steps, optional Z at the end.
// Assumes go is raised only while idle; released data lines keep toggling.
`default_nettype none
module cfs_enc_model (
  input  wire logic               ref_clk,       // Control clock
  input  wire logic               go,            // Start a burst
  input  wire logic [7:0]         cnt,           // Steps in burst
  input  wire logic signed [15:0] step,          // Step size
  input  wire logic               mark_last,     // Z with last step
  output logic                    load_vld,      // Step valid
  output logic signed [15:0]      load_delta,    // Step
  output logic                    load_ref_mark  // Reference mark
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_r = 8'h00;
  initial begin
    load_vld = 1'b0;
    load_delta = 16'h0000;
    load_ref_mark = 1'b0;
  end
  always @(posedge ref_clk) begin
    if (left_r != 8'h00) begin
      load_vld <= 1'b1;
      load_delta <= step;
      load_ref_mark <= mark_last && left_r == 8'h01;
      left_r <= left_r - 8'h01;
    end else begin
      load_vld <= 1'b0;
      load_delta <= ~load_delta; // Stale data must not look valid
      load_ref_mark <= 1'b0;
      if (go) left_r <= cnt;
    end
  end
endmodule // cfs_enc_model
`default_nettype wire

// *** verification/cfs_top_props.sv ***
// Checker for cfs_top: loop selection outputs and bus answer timing.
// Assumes it is bound to cfs_top and sees only that module's ports.
`default_nettype none
`include "cfs_defs.vh"
module cfs_top_props (
  input wire logic        ref_clk,       // Control clock
  input wire logic        nrst,          // Async reset, active low
  input wire logic        load_is_abs,   // Load encoder is absolute
  input wire logic [1:0]  ctl_mode_r,    // Control mode
  input wire logic        load_units_r,  // Load units selected
  input wire logic        abs_avail_r,   // Absolute detection ok
  input wire logic        dev_alarm_r,   // Deviation alarm
  input wire logic        s_axi_awvalid, // Write address valid
  input wire logic        s_axi_awready, // Write address ready
  input wire logic [1:0]  s_axi_bresp,   // Write response
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_bready,  // Write response ready
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        s_axi_rready   // Read data ready
);
  // Outputs only settle a few edges after release: two sync flops first
  logic [2:0] up_cnt_r;
  logic       live;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) up_cnt_r <= 3'h0;
    else if (up_cnt_r != 3'h7) up_cnt_r <= up_cnt_r + 3'h1;
  end
  assign live = up_cnt_r == 3'h7;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence b_soon;
    ##[1:8] s_axi_bvalid;
  endsequence
  mode_range_a: assert property (ctl_mode_r != 2'h3)
    else $error("control mode code out of range");
  semi_units_a: assert property (
    !load_units_r |-> ctl_mode_r == `CFS_CTL_SEMI)
    else $error("semi system left semi control");
  semi_abs_a: assert property (live && !load_units_r |-> abs_avail_r)
    else $error("absolute detection missing in semi system");
  abs_source_a: assert property (
    live && abs_avail_r && load_units_r |-> $past(load_is_abs))
    else $error("absolute detection without absolute encoder");
  dev_full_a: assert property (dev_alarm_r |-> load_units_r)
    else $error("deviation alarm outside full system");
  wr_answer_a: assert property (aw_taken |-> b_soon)
    else $error("write response late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule // cfs_top_props
`default_nettype wire

// *** verification/closed_loop_feedback_select_bench.sv ***
// Self-checking bench for cfs_top with a load encoder model.
// Assumes cfs_defs.vh on the include path; bench is the bus master.
`default_nettype none
`include "cfs_defs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module closed_loop_feedback_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] ctrl; logic [14:0] filt; logic cmd; logic abs;
    logic [1:0] ctl; logic units; logic av;
  } cfs_row_t;
  logic ref_clk = 0, nrst = 0, mot_vld = 0, load_is_abs = 0;
  logic full_loop_cmd = 0, go = 0, mark_last = 0;
  logic signed [15:0] mot_delta = 0, step = 0, load_delta;
  logic [7:0] cnt = 0, awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, load_vld, load_ref_mark;
  logic [1:0] bresp, rresp, ctl_mode_r, r;
  logic units, av, par, dev, irq;
  logic signed [31:0] fb;
  int failures = 0, checks_done = 0, cyc = 0, lag = 0;
  cfs_row_t rows [8] = '{
    '{3'h0, 15'h000a, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1},
    '{3'h0, 15'h4650, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1},
    '{3'h1, 15'h0000, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1},
    '{3'h1, 15'h4650, 1'b0, 1'b1, 2'h2, 1'b1, 1'b1},
    '{3'h1, 15'h000a, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0},
    '{3'h3, 15'h000a, 1'b0, 1'b1, 2'h0, 1'b1, 1'b0},
    '{3'h3, 15'h000a, 1'b1, 1'b1, 2'h2, 1'b1, 1'b0},
    '{3'h1, 15'h464f, 1'b1, 1'b1, 2'h1, 1'b1, 1'b1}};
  logic [7:0] rst_a [6] = '{8'h00, 8'h04, 8'h14, 8'h18, 8'h1c, 8'h3c};
  logic [31:0] rst_v [6] = '{32'h0, 32'h1, 32'h0a, 32'h100000, 32'h400000, 32'h0};
  cfs_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .mot_vld(mot_vld),
    .mot_delta(mot_delta), .load_vld(load_vld), .load_delta(load_delta),
    .load_ref_mark(load_ref_mark), .load_is_abs(load_is_abs),
    .full_loop_cmd(full_loop_cmd), .ctl_mode_r(ctl_mode_r),
    .load_units_r(units), .abs_avail_r(av), .fb_pos_r(fb),
    .par_alarm_r(par), .dev_alarm_r(dev), .irq_r(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cfs_enc_model enc_u (.ref_clk(ref_clk), .go(go), .cnt(cnt), .step(step),
    .mark_last(mark_last), .load_vld(load_vld), .load_delta(load_delta),
    .load_ref_mark(load_ref_mark));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    @(posedge ref_clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= lag == 0;
    aw = 0; w = 0;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (awready && awvalid) begin aw = 1; awvalid <= 0; end
      if (wready && wvalid) begin w = 1; wvalid <= 0; end
    end
    repeat (lag) @(posedge ref_clk);
    bready <= 1;
    do @(posedge ref_clk); while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= lag == 0;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 0;
    repeat (lag) @(posedge ref_clk);
    rready <= 1;
    do @(posedge ref_clk); while (!rvalid);
    d = rdata; r = rresp;
    rready <= 0;
  endtask
  task automatic mot(input int n, input logic signed [15:0] v);
    repeat (n) begin
      @(posedge ref_clk); mot_vld <= 1; mot_delta <= v;
    end
    @(posedge ref_clk); mot_vld <= 0; mot_delta <= ~v;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic load(input logic [7:0] n, input logic signed [15:0] v,
                      input logic z);
    @(posedge ref_clk); go <= 1; cnt <= n; step <= v; mark_last <= z;
    @(posedge ref_clk); go <= 0;
    repeat (n + 5) @(posedge ref_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin failures++; wrap_up(); end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1;
    repeat (4) @(posedge ref_clk);
    foreach (rst_a[i]) begin rd(rst_a[i]); `CHK(d, rst_v[i]) end
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(8'h00, {29'h0, rows[i].ctrl});
      wr(8'h14, {17'h0, rows[i].filt});
      full_loop_cmd <= rows[i].cmd; load_is_abs <= rows[i].abs;
      repeat (3) @(posedge ref_clk);
      `CHK(ctl_mode_r, rows[i].ctl)
      `CHK({units, av}, {rows[i].units, rows[i].av})
    end
    $display("test mode table done");
    wr(8'h14, 32'h4650); wr(8'h00, 32'h1);
    wr(8'h04, 32'd3125); wr(8'h08, 32'd1);
    wr(8'h0c, 32'd32768); wr(8'h10, 32'd11);
    wr(8'h40, 32'h7);
    mot(22, 16'sd16384);
    rd(8'h24); `CHK(d, 32'd360448)
    rd(8'h28); `CHK(d, 32'd3125)
    load(8'd25, 16'sd125, 1'b1);
    rd(8'h2c); `CHK(d, 32'd3125)
    `CHK(fb, 32'sd3125)
    rd(8'h30); `CHK(d, 32'd0)
    rd(8'h38); `CHK(d[2:0], 3'h4)
    `CHK({par, dev, irq}, 3'h0)
    wr(8'h3c, 32'h4); repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b1)
    wr(8'h40, 32'h4); repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    $display("test gear and reference mark done");
    wr(8'h00, 32'h5);
    load(8'd10, 16'sd7, 1'b0);
    rd(8'h2c); `CHK(d, 32'd3055)
    wr(8'h14, 32'd9000); repeat (3) @(posedge ref_clk);
    `CHK(fb, 32'sd3090)
    wr(8'h18, 32'd10); repeat (3) @(posedge ref_clk);
    `CHK(dev, 1'b1)
    wr(8'h04, 32'd1); wr(8'h10, 32'd1); wr(8'h0c, 32'd1024);
    repeat (3) @(posedge ref_clk);
    `CHK(par, 1'b0)
    wr(8'h0c, 32'd1025); repeat (3) @(posedge ref_clk);
    `CHK(par, 1'b1)
    rd(8'h38); `CHK(d[2:0], 3'h3)
    $display("test alarms done");
    lag = 3;
    rd(8'h44); `CHK({r, d}, {2'h2, 32'h0})
    wr(8'h44, 32'h1); `CHK(r, 2'h2)
    $display("test unmapped access done");
    wrap_up();
  end
endmodule // closed_loop_feedback_select_bench
bind cfs_top cfs_top_props props_u (.ref_clk(ref_clk), .nrst(nrst),
  .load_is_abs(load_is_abs), .ctl_mode_r(ctl_mode_r),
  .load_units_r(load_units_r), .abs_avail_r(abs_avail_r),
  .dev_alarm_r(dev_alarm_r), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
